/* File: logic/dwp_flash_port.sv */
`timescale 1ns/100ps
`include "dwp_map.svh"

// Summary of operation
// - control register at 0x02, resets zero
// - enable only after 0x02 then 0x01
// - programming stays enabled until system reset
// - data register at 0xb4, resets zero
// - commands 06 read, 07 write, 08/03 erase
// - pins taken over only while core halted
// - address register selects data read/write target
module dwp_flash_port
    import dwp_pkg::*;
(
    input wire logic clk, // system clock, 10 MHz
    input wire logic rst_n, // synchronous system reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic core_halted, // core halted, same clock
    input wire logic debug_link_clock_pin, // link clock from host
    input wire logic debug_link_data_pin_in, // data pin level
    output logic debug_link_data_pin_out, // data pin drive value
    output logic debug_link_data_pin_oe, // data pin driven when high
    output logic pin_takeover, // debug port owns shared pins
    output logic prog_enabled, // flash programming unlocked
    output logic flash_cmd_strobe, // one-cycle valid command
    output logic [7:0] flash_cmd, // command code
    output logic flash_byte_strobe, // one-cycle address/data byte
    output logic [7:0] flash_byte, // address/data byte
    input wire logic flash_done, // flash finished current command
    input wire logic flash_rd_valid, // flash read byte valid
    input wire logic [7:0] flash_rd_byte // flash read byte
);

    ////////////////////////////////////////////////////////////////////////

    dwp_state_s r_reg;
    dwp_state_s r_next;
    logic data_lvl;
    logic clk_rise;
    logic clk_fall;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    dwp_pin_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clk_pin(debug_link_clock_pin),
        .data_pin(debug_link_data_pin_in),
        .data_lvl(data_lvl),
        .clk_rise(clk_rise),
        .clk_fall(clk_fall)
    );

    function automatic logic is_cmd(input logic [7:0] c);
        is_cmd = (c == `DWP_CMD_BLOCK_RD) || (c == `DWP_CMD_BLOCK_WR) ||
                 (c == `DWP_CMD_PAGE_ERASE) || (c == `DWP_CMD_DEV_ERASE);
    endfunction

    // unmapped addresses read as zero
    function automatic logic [7:0] read_mux(input dwp_state_s s);
        case (s.addr_sel)
            `DWP_ADDR_CTL: read_mux = s.ctl;
            `DWP_ADDR_DAT: read_mux = s.dat;
            default: read_mux = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        r_next = r_reg;
        r_next.cmd_strobe = 1'b0;
        r_next.byte_strobe = 1'b0;
        r_next.pin_take = core_halted;
        wbyte = {data_lvl, r_reg.in_shift[7:1]};
        rbyte = (r_reg.ins == `DWP_INS_ADDR_RD) ? r_reg.addr_sel : read_mux(r_reg);
        if (flash_done) begin
            r_next.cmd_phase = 1'b1;
        end
        // host writes below take priority over this load
        if (flash_rd_valid) begin
            r_next.dat = flash_rd_byte;
        end
        if (clk_rise) begin
            r_next.idle_cnt = 8'h00;
        end else if (r_reg.idle_cnt != 8'(`DWP_TIMEOUT_CYC)) begin
            r_next.idle_cnt = r_reg.idle_cnt + 8'h01;
        end
        // a rise after a long idle is the next start bit, so it must not be swallowed
        if (!core_halted || (r_reg.idle_cnt == 8'(`DWP_TIMEOUT_CYC) && !clk_rise)) begin
            // pins only borrowed while halted; stalled frame abandoned
            r_next.bit_cnt = `DWP_BIT_START;
            r_next.data_oe = 1'b0;
        end else if (clk_rise) begin
            r_next.bit_cnt = (r_reg.bit_cnt == `DWP_BIT_STOP) ? `DWP_BIT_START
                                                              : r_reg.bit_cnt + 4'h1;
            if (r_reg.bit_cnt == `DWP_BIT_INS0) begin
                r_next.ins[0] = data_lvl;
            end else if (r_reg.bit_cnt == `DWP_BIT_INS1) begin
                r_next.ins[1] = data_lvl;
            end else if (r_reg.bit_cnt >= `DWP_BIT_DATA0 &&
                         r_reg.bit_cnt <= `DWP_BIT_DATA7) begin
                r_next.in_shift = wbyte;
            end
            if (r_reg.bit_cnt == `DWP_BIT_DATA7) begin
                if (r_reg.ins == `DWP_INS_ADDR_WR) begin
                    r_next.addr_sel = wbyte;
                end else if (r_reg.ins == `DWP_INS_DATA_WR) begin
                    case (r_reg.addr_sel)
                        `DWP_ADDR_CTL: begin
                            r_next.ctl = wbyte;
                            case (r_reg.unlock)
                                dwp_enabled: r_next.unlock = dwp_enabled;
                                dwp_half: begin
                                    if (wbyte == `DWP_UNLOCK_SECOND) begin
                                        r_next.unlock = dwp_enabled;
                                    end else if (wbyte == `DWP_UNLOCK_FIRST) begin
                                        r_next.unlock = dwp_half;
                                    end else begin
                                        r_next.unlock = dwp_locked;
                                    end
                                end
                                default: begin
                                    r_next.unlock = (wbyte == `DWP_UNLOCK_FIRST) ? dwp_half
                                                                                  : dwp_locked;
                                end
                            endcase
                        end
                        `DWP_ADDR_DAT: begin
                            r_next.dat = wbyte;
                            if (r_reg.unlock == dwp_enabled) begin
                                if (r_reg.cmd_phase) begin
                                    // unknown codes dropped, port stays in command phase
                                    if (is_cmd(wbyte)) begin
                                        r_next.cmd_strobe = 1'b1;
                                        r_next.cmd = wbyte;
                                        r_next.cmd_phase = 1'b0;
                                    end
                                end else begin
                                    r_next.byte_strobe = 1'b1;
                                    r_next.flash_byte = wbyte;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end else if (clk_fall) begin
            // drive on falling edge so host samples a settled bit on rising
            if (r_reg.bit_cnt == `DWP_BIT_DATA0 && !r_reg.ins[0]) begin
                r_next.data_out = rbyte[0];
                r_next.out_shift = {1'b0, rbyte[7:1]};
                r_next.data_oe = 1'b1;
            end else if (r_reg.bit_cnt == `DWP_BIT_STOP) begin
                r_next.data_oe = 1'b0;
            end else if (r_reg.data_oe) begin
                r_next.data_out = r_reg.out_shift[0];
                r_next.out_shift = {1'b0, r_reg.out_shift[7:1]};
            end
        end
        r_next.prog_en = (r_next.unlock == dwp_enabled);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.addr_sel <= `DWP_RST_ADDR;
            r_reg.ctl <= `DWP_RST_CTL;
            r_reg.dat <= `DWP_RST_DAT;
            r_reg.unlock <= dwp_locked;
            r_reg.cmd_phase <= 1'b1;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign debug_link_data_pin_out = r_reg.data_out;
    assign debug_link_data_pin_oe = r_reg.data_oe;
    assign pin_takeover = r_reg.pin_take;
    assign prog_enabled = r_reg.prog_en;
    assign flash_cmd_strobe = r_reg.cmd_strobe;
    assign flash_cmd = r_reg.cmd;
    assign flash_byte_strobe = r_reg.byte_strobe;
    assign flash_byte = r_reg.flash_byte;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_ctl_reset_zero: assert property ($rose(rst_n) |-> r_reg.ctl == 8'h00)
        else $error("control register not zero after reset");
    a_unlock_order: assert property ($rose(prog_enabled) |-> $past(r_reg.unlock) == dwp_half)
        else $error("programming enabled without first unlock code");
    a_enable_sticky: assert property (prog_enabled && ce |=> prog_enabled)
        else $error("programming enable dropped without reset");
    a_dat_reset_zero: assert property ($rose(rst_n) |-> r_reg.dat == 8'h00)
        else $error("data register not zero after reset");
    a_flash_load: assert property (ce && flash_rd_valid && !clk_rise |=>
                                   r_reg.dat == $past(flash_rd_byte))
        else $error("flash read byte not loaded");
    a_cmd_code_valid: assert property (flash_cmd_strobe |-> is_cmd(flash_cmd))
        else $error("invalid flash command issued");
    a_pin_release: assert property (ce && !core_halted |=> !debug_link_data_pin_oe)
        else $error("data pin driven while core running");
    a_read_select: assert property ($rose(debug_link_data_pin_oe) &&
                                    r_reg.ins == `DWP_INS_DATA_RD &&
                                    r_reg.addr_sel == `DWP_ADDR_CTL |->
                                    debug_link_data_pin_out == r_reg.ctl[0])
        else $error("read did not follow selected register");
    a_locked_no_cmd: assert property (flash_cmd_strobe || flash_byte_strobe |->
                                      prog_enabled)
        else $error("flash traffic while locked");

    c_prog_enabled: cover property ($rose(prog_enabled));
    c_cmd_issued: cover property (flash_cmd_strobe);
    c_byte_passed: cover property (flash_byte_strobe);
    c_read_drive: cover property ($rose(debug_link_data_pin_oe));

endmodule

/* File: logic/dwp_map.svh */
`ifndef DWP_MAP_SVH
`define DWP_MAP_SVH

// debug-port register addresses
`define DWP_ADDR_CTL 8'h02
`define DWP_ADDR_DAT 8'hb4

// reset values
`define DWP_RST_ADDR 8'h00
`define DWP_RST_CTL 8'h00
`define DWP_RST_DAT 8'h00

// unlock codes, in the order written
`define DWP_UNLOCK_FIRST 8'h02
`define DWP_UNLOCK_SECOND 8'h01

// flash command codes
`define DWP_CMD_BLOCK_RD 8'h06
`define DWP_CMD_BLOCK_WR 8'h07
`define DWP_CMD_PAGE_ERASE 8'h08
`define DWP_CMD_DEV_ERASE 8'h03

// link instruction codes
`define DWP_INS_DATA_RD 2'h0
`define DWP_INS_DATA_WR 2'h1
`define DWP_INS_ADDR_RD 2'h2
`define DWP_INS_ADDR_WR 2'h3

// frame bit positions, counted in link clock rising edges
`define DWP_BIT_START 4'h0
`define DWP_BIT_INS0 4'h1
`define DWP_BIT_INS1 4'h2
`define DWP_BIT_DATA0 4'h3
`define DWP_BIT_DATA7 4'ha
`define DWP_BIT_STOP 4'hb

// timing
`define DWP_CLK_PERIOD_NS 100
`define DWP_TIMEOUT_NS 20000
`define DWP_TIMEOUT_CYC (`DWP_TIMEOUT_NS / `DWP_CLK_PERIOD_NS)

`endif

/* File: logic/dwp_pin_sync.sv */
`timescale 1ns/100ps

module dwp_pin_sync
    import dwp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic ce, // clock enable
    input wire logic clk_pin, // raw link clock pin
    input wire logic data_pin, // raw link data pin
    output logic data_lvl, // synchronised data level
    output logic clk_rise, // link clock rising edge seen
    output logic clk_fall // link clock falling edge seen
);

    dwp_sync_s s_reg;
    dwp_sync_s s_next;

    always_comb begin
        s_next = s_reg;
        s_next.clk_s1 = clk_pin;
        s_next.clk_s2 = s_reg.clk_s1;
        s_next.clk_s3 = s_reg.clk_s2;
        s_next.dat_s1 = data_pin;
        s_next.dat_s2 = s_reg.dat_s1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            // link clock idles high: reset to that level so no false rise follows
            s_reg.clk_s1 <= 1'b1;
            s_reg.clk_s2 <= 1'b1;
            s_reg.clk_s3 <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // only second and later stages are looked at
    assign data_lvl = s_reg.dat_s2;
    assign clk_rise = s_reg.clk_s2 & ~s_reg.clk_s3;
    assign clk_fall = ~s_reg.clk_s2 & s_reg.clk_s3;

endmodule

/* File: logic/dwp_pkg.sv */
package dwp_pkg;

    typedef enum logic [1:0] {
        dwp_locked,
        dwp_half,
        dwp_enabled
    } dwp_unlock_e;

    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic dat_s1;
        logic dat_s2;
    } dwp_sync_s;

    typedef struct packed {
        logic [3:0] bit_cnt;
        logic [1:0] ins;
        logic [7:0] in_shift;
        logic [7:0] out_shift;
        logic [7:0] idle_cnt;
        logic [7:0] addr_sel;
        logic [7:0] ctl;
        logic [7:0] dat;
        dwp_unlock_e unlock;
        logic cmd_phase;
        logic prog_en;
        logic pin_take;
        logic data_out;
        logic data_oe;
        logic cmd_strobe;
        logic [7:0] cmd;
        logic byte_strobe;
        logic [7:0] flash_byte;
    } dwp_state_s;

endpackage

/* File: testbench/dwp_host_model.sv */
`timescale 1ns/100ps

module dwp_host_model (
    input wire logic clk, // pacing clock
    input wire logic dev_out, // device drive value
    input wire logic dev_oe, // device drives pin
    output logic lclk, // link clock pin
    output logic lwire // resolved data pin
);
    logic hd = 1'b0;
    logic hoe = 1'b0;
    logic last = 1'b0;
    // idles high: the pin doubles as reset
    initial lclk = 1'b1;
    // no pull on the wire, so a released pin keeps changing
    assign lwire = dev_oe ? dev_out : (hoe ? hd : ~last);
    always @(posedge clk) last <= lwire;
    ////////////////////////////////////////
    // start, two instruction bits, eight data bits lsb first, stop
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                         output logic [7:0] rd);
        logic [11:0] b;
        logic r;
        b = {1'b0, wd, ins, 1'b0};
        r = !ins[0];
        rd = 8'h00;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            lclk <= 1'b0;
            hoe <= !(r && i > 2);
            hd <= b[i];
            repeat (4) @(posedge clk);
            lclk <= 1'b1;
            repeat (3) @(posedge clk);
            if (r && i > 2 && i < 11) begin
                rd[i - 3] = lwire;
            end
        end
        @(posedge clk);
        hoe <= 1'b0;
    endtask
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "dwp_map.svh"

module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic halt = 1'b0;
    logic fdone = 1'b0;
    logic frv = 1'b0;
    logic [7:0] frb = 8'h00;
    logic lclk, lwire, dout, doe, take, pen, cstb, bstb;
    logic [7:0] cmd, fbyte, last_cmd, last_byte, v;
    int error_cnt = 0;
    int cmp_count = 0;
    int ncmd = 0;
    int nbyte = 0;
    logic [7:0] cmds [4] = '{`DWP_CMD_BLOCK_RD, `DWP_CMD_BLOCK_WR,
                             `DWP_CMD_PAGE_ERASE, `DWP_CMD_DEV_ERASE};

    always #50 clk = ~clk;

    dwp_flash_port dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .core_halted(halt),
        .debug_link_clock_pin(lclk), .debug_link_data_pin_in(lwire),
        .debug_link_data_pin_out(dout), .debug_link_data_pin_oe(doe),
        .pin_takeover(take), .prog_enabled(pen), .flash_cmd_strobe(cstb),
        .flash_cmd(cmd), .flash_byte_strobe(bstb), .flash_byte(fbyte),
        .flash_done(fdone), .flash_rd_valid(frv), .flash_rd_byte(frb)
    );
    dwp_host_model host (
        .clk(clk), .dev_out(dout), .dev_oe(doe), .lclk(lclk), .lwire(lwire)
    );

    always @(posedge clk) begin
        if (cstb === 1'b1) begin
            ncmd++;
            last_cmd = cmd;
        end
        if (bstb === 1'b1) begin
            nbyte++;
            last_byte = fbyte;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sel(input logic [7:0] a);
        host.frame(`DWP_INS_ADDR_WR, a, v);
    endtask
    task automatic dwr(input logic [7:0] d);
        host.frame(`DWP_INS_DATA_WR, d, v);
    endtask
    task automatic drd(input logic [7:0] e);
        host.frame(`DWP_INS_DATA_RD, 8'h00, v);
        chk(v, e);
    endtask
    task automatic finish_cmd;
        @(posedge clk);
        fdone <= 1'b1;
        @(posedge clk);
        fdone <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // core still running: this frame must be refused
        sel(`DWP_ADDR_DAT);
        chk({7'h00, take}, 8'h00);
        halt <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h00, take}, 8'h01);
        // idle past the frame timeout; the next frame must still line up
        repeat (250) @(posedge clk);
        host.frame(`DWP_INS_ADDR_RD, 8'h00, v);
        chk(v, `DWP_RST_ADDR);
        sel(`DWP_ADDR_CTL);
        drd(`DWP_RST_CTL);
        sel(`DWP_ADDR_DAT);
        host.frame(`DWP_INS_ADDR_RD, 8'h00, v);
        chk(v, `DWP_ADDR_DAT);
        drd(`DWP_RST_DAT);
        dwr(`DWP_CMD_BLOCK_WR);
        chk(8'(ncmd), 8'h00);
        drd(`DWP_CMD_BLOCK_WR);
        sel(`DWP_ADDR_CTL);
        // codes in the wrong order, then a stray value
        dwr(`DWP_UNLOCK_SECOND);
        dwr(`DWP_UNLOCK_FIRST);
        dwr(8'h03);
        chk({7'h00, pen}, 8'h00);
        drd(8'h03);
        dwr(`DWP_UNLOCK_FIRST);
        dwr(`DWP_UNLOCK_SECOND);
        chk({7'h00, pen}, 8'h01);
        dwr(8'h00);
        chk({7'h00, pen}, 8'h01);
        sel(`DWP_ADDR_DAT);
        foreach (cmds[k]) begin
            dwr(cmds[k]);
            chk(8'(ncmd), 8'(k + 1));
            chk(last_cmd, cmds[k]);
            finish_cmd;
        end
        dwr(8'h05);
        chk(8'(ncmd), 8'h04);
        dwr(`DWP_CMD_BLOCK_WR);
        dwr(8'h5a);
        chk(last_byte, 8'h5a);
        chk(8'(nbyte), 8'h01);
        finish_cmd;
        @(posedge clk);
        frv <= 1'b1;
        frb <= 8'hc3;
        @(posedge clk);
        frv <= 1'b0;
        drd(8'hc3);
        // clock enable low: a flash read byte offered then must not load
        @(posedge clk);
        ce <= 1'b0;
        frv <= 1'b1;
        frb <= 8'h3c;
        @(posedge clk);
        frv <= 1'b0;
        ce <= 1'b1;
        @(posedge clk);
        drd(8'hc3);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({7'h00, pen}, 8'h00);
        repeat (3) @(posedge clk);
        sel(`DWP_ADDR_CTL);
        drd(`DWP_RST_CTL);
        give_verdict;
    end

    // 29 frames of about 100 cycles each, plus a 250-cycle idle; allow about six times that
    initial begin
        #2000000;
        error_cnt++;
        give_verdict;
    end
endmodule
